// *** rtl/mpit_pkg.sv ***
/*
  Shared constants, types and helpers for the media independent PHY-side block:
  clock and bit timing per speed, receive launch window, management frame layout.
  Assumes a 100 MHz system clock from which all link timing is counted.
*/
package mpit_pkg;

  localparam int CLK_NS     = 10;
  localparam int NIB_100_NS = 40;
  localparam int NIB_10_NS  = 400;
  localparam int BIT_100_NS = 10;
  localparam int BIT_10_NS  = 100;

  localparam int CW = 6;
  localparam int BW = 4;

  localparam logic [CW-1:0] NIB_100_CYC = CW'(NIB_100_NS / CLK_NS);
  localparam logic [CW-1:0] NIB_10_CYC  = CW'(NIB_10_NS / CLK_NS);
  localparam logic [BW-1:0] BIT_100_CYC = BW'(BIT_100_NS / CLK_NS);
  localparam logic [BW-1:0] BIT_10_CYC  = BW'(BIT_10_NS / CLK_NS);

  // transmit pins are taken one cycle after the rising edge of the nibble clock
  localparam logic [CW-1:0] TX_TAKE_PHASE = 6'h00;
  // receive outputs may change only while the counter is inside this window
  localparam logic [CW-1:0] RX_LAUNCH_FIRST = 6'h01;
  localparam logic [CW-1:0] RX_LAUNCH_TAIL  = 6'h03;

  localparam logic [1:0] NIB_LAST = 2'h3;

  localparam logic [5:0] MG_PRE_BITS = 6'h20;
  localparam logic [4:0] MG_HDR_LAST = 5'h0B;
  localparam logic [4:0] MG_TA_SLOT  = 5'h00;
  localparam logic [4:0] MG_WR_FIRST = 5'h02;
  localparam logic [4:0] MG_LAST     = 5'h11;
  localparam logic [1:0] MG_OP_RD    = 2'h2;
  localparam logic [1:0] MG_OP_WR    = 2'h1;

  typedef enum logic [1:0] {
    MG_IDLE  = 2'b00,
    MG_START = 2'b01,
    MG_HDR   = 2'b10,
    MG_DATA  = 2'b11
  } mpit_mgmt_state_t;

  function automatic logic [CW-1:0] nib_cycles(input logic fast);
    nib_cycles = fast ? NIB_100_CYC : NIB_10_CYC;
  endfunction

  function automatic logic [BW-1:0] bit_cycles(input logic fast);
    bit_cycles = fast ? BIT_100_CYC : BIT_10_CYC;
  endfunction

endpackage

// *** rtl/mpit_fifo.sv ***
/*
  First-word-fall-through FIFO with valid/ready on both sides; read data
  comes from a register. Assumes DEPTH is a power of two and one clock.
*/
`timescale 1ns/1ns
module mpit_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             refill;
  logic             from_mem;
  logic             bypass;
  logic             to_mem;

  assign push     = in_valid && in_ready;
  assign refill   = !out_valid || out_ready;
  assign from_mem = refill && (count != '0);
  assign bypass   = refill && (count == '0) && push;
  assign to_mem   = push && !bypass;

  always_comb begin
    next_count = count;
    if (to_mem && !from_mem) begin
      next_count = count + 1'b1;
    end else if (!to_mem && from_mem) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (to_mem) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr     <= '0;
      rptr     <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (to_mem) begin
        wptr <= wptr + 1'b1;
      end
      if (from_mem) begin
        rptr <= rptr + 1'b1;
      end
      count    <= next_count;
      in_ready <= next_count < (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (refill) begin
      out_valid <= from_mem || bypass;
      if (from_mem) begin
        out_data <= mem[rptr];
      end else if (bypass) begin
        out_data <= in_data;
      end
    end
  end

endmodule

// *** rtl/mpit_top.sv ***
/*
  PHY side of the media independent interface: nibble clocks, transmit
  capture and serialisation to the line, line reception to receive nibbles,
  carrier sense and the management serial port.
  Assumes every pin input is asynchronous to clk_sys; mgmt_rdata is on clk_sys.
*/
`timescale 1ns/1ns
// Behaviour
// - Transmit clock period 40 ns fast, 400 ns slow, duty within 35..65 percent.
// - Receive clock period 40 ns fast, 400 ns slow, duty within 35..65 percent.
// - MAC sets transmit nibble, enable, error per clock; device takes them at rise.
// - Receive nibble, valid, error stable around rising receive clock; MAC samples there.
// - Management read bit valid at most 300 ns after management clock rise.
// - Slow speed: received data reaches receive outputs within 7 bit times.
// - Slow speed: first line bit within 2 bit times after nibble taken.
// - Fast speed: first line bit within 3 bit times after enable taken.
// - Fast half duplex: carrier sense rises 0..4 bit times after enable taken; code raises it about one bit time before the rise that takes the enable.
// - Fast half duplex: carrier sense falls 0..4 bit times after enable drops.
// - Slow half duplex: carrier sense rises 0..2 bit times after enable rises.
// - Slow speed bit time is 100 ns.
module mpit_top #(
  parameter logic [4:0] PHY_ADDR   = 5'h00,
  parameter int         FIFO_DEPTH = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        speed_100,
  input  wire logic        full_duplex,
  output logic             tx_clk,
  input  wire logic [3:0]  txd,
  input  wire logic        tx_en,
  input  wire logic        tx_er,
  output logic             rx_clk,
  output logic      [3:0]  rxd,
  output logic             rx_dv,
  output logic             rx_er,
  output logic             crs,
  output logic             line_transmit_pair,
  output logic             line_transmit_active,
  output logic             line_transmit_error,
  input  wire logic        line_receive_pair,
  input  wire logic        line_receive_valid,
  input  wire logic        line_receive_error,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [15:0] mgmt_rdata,
  output logic      [4:0]  mgmt_addr,
  output logic      [15:0] mgmt_wdata,
  output logic             mgmt_write
);
  localparam int CW = mpit_pkg::CW;
  localparam int BW = mpit_pkg::BW;
  localparam int SW = 13;

  logic                         rst_s1;
  logic                         rst_n;
  logic [SW-1:0]                pin_s1;
  logic [SW-1:0]                pin_s2;
  logic                         fast;
  logic                         spd_fast;
  logic                         half_dup;
  logic [3:0]                   txd_s;
  logic                         tx_en_s;
  logic                         tx_er_s;
  logic                         lrx_s;
  logic                         lvalid_s;
  logic                         lerr_s;
  logic                         mdc_s;
  logic                         mdio_s;
  logic                         mdc_d;
  logic [CW-1:0]                ctr;
  logic [CW-1:0]                next_ctr;
  logic [CW-1:0]                per;
  logic [BW-1:0]                bitc;
  logic                         fifo_in_ready;
  logic                         fifo_out_valid;
  logic [4:0]                   fifo_out_data;
  logic                         ser_load;
  logic [BW-1:0]                tx_bt;
  logic [2:0]                   tx_sh;
  logic [1:0]                   tx_left;
  logic                         rx_frame;
  logic [BW-1:0]                rx_bt;
  logic [3:0]                   rx_sh;
  logic [1:0]                   rx_cnt;
  logic                         rx_errf;
  logic [4:0]                   rx_nib;
  logic                         rx_pending;
  logic                         rx_launched;
  logic                         launch_now;
  logic                         nib_done;
  mpit_pkg::mpit_mgmt_state_t   mg_state;
  logic [5:0]                   pre_cnt;
  logic [4:0]                   mg_cnt;
  logic [11:0]                  hdr;
  logic [11:0]                  next_hdr;
  logic [15:0]                  mg_sh;
  logic                         mg_read;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // every pin input passes two flops before use
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      mdc_d  <= 1'b0;
    end else begin
      pin_s1 <= {speed_100, full_duplex, txd, tx_en, tx_er, line_receive_pair,
                 line_receive_valid, line_receive_error, mdc, mdio_in};
      pin_s2 <= pin_s1;
      mdc_d  <= mdc_s;
    end
  end

  assign {fast, half_dup, txd_s, tx_en_s, tx_er_s, lrx_s, lvalid_s, lerr_s,
          mdc_s, mdio_s} = {pin_s2[12], !pin_s2[11], pin_s2[10:0]};

  assign per  = mpit_pkg::nib_cycles(spd_fast);
  assign bitc = mpit_pkg::bit_cycles(spd_fast);
  assign next_ctr = (ctr >= per - 1'b1) ? '0 : ctr + 1'b1;

  // one divider feeds both nibble clocks, high for exactly half the period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctr      <= mpit_pkg::NIB_10_CYC - 1'b1;
      spd_fast <= 1'b0;
      tx_clk   <= 1'b0;
      rx_clk   <= 1'b0;
    end else begin
      ctr    <= next_ctr;
      // speed is taken only at the wrap so no clock phase is cut short
      if (ctr >= per - 1'b1) begin
        spd_fast <= fast;
      end
      tx_clk <= next_ctr < (per >> 1);
      rx_clk <= next_ctr < (per >> 1);
    end
  end

  // pins are taken one cycle after the rise; a full buffer drops the nibble
  mpit_fifo #(
    .WIDTH (5),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk       (clk_sys),
    .rst_n     (rst_n),
    .in_valid  ((ctr == mpit_pkg::TX_TAKE_PHASE) && tx_en_s),
    .in_ready  (fifo_in_ready),
    .in_data   ({tx_er_s, txd_s}),
    .out_valid (fifo_out_valid),
    .out_ready (ser_load),
    .out_data  (fifo_out_data)
  );

  assign ser_load = fifo_out_valid && (tx_bt == '0) && (tx_left == '0);

  // serialiser sends each nibble low bit first, one bit per bit time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_bt                <= '0;
      tx_sh                <= '0;
      tx_left              <= '0;
      line_transmit_pair   <= 1'b0;
      line_transmit_active <= 1'b0;
      line_transmit_error  <= 1'b0;
    end else if (tx_bt != '0) begin
      tx_bt <= tx_bt - 1'b1;
    end else if (tx_left != '0) begin
      line_transmit_pair <= tx_sh[0];
      tx_sh              <= {1'b0, tx_sh[2:1]};
      tx_left            <= tx_left - 1'b1;
      tx_bt              <= bitc - 1'b1;
    end else if (ser_load) begin
      line_transmit_pair   <= fifo_out_data[0];
      tx_sh                <= fifo_out_data[3:1];
      line_transmit_error  <= fifo_out_data[4];
      line_transmit_active <= 1'b1;
      tx_left              <= mpit_pkg::NIB_LAST;
      tx_bt                <= bitc - 1'b1;
    end else begin
      line_transmit_pair   <= 1'b0;
      line_transmit_active <= 1'b0;
      line_transmit_error  <= 1'b0;
    end
  end

  // in half duplex carrier follows the synchronised enable tx_en_s through one register, so it leads the sampling edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      crs <= 1'b0;
    end else begin
      crs <= (half_dup && tx_en_s) || rx_frame;
    end
  end

  assign nib_done = rx_frame && lvalid_s && (rx_bt == '0) && (rx_cnt == mpit_pkg::NIB_LAST);

  // line receiver: sample mid bit, gather nibbles low bit first
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_frame   <= 1'b0;
      rx_bt      <= '0;
      rx_sh      <= '0;
      rx_cnt     <= '0;
      rx_errf    <= 1'b0;
      rx_nib     <= '0;
      rx_pending <= 1'b0;
    end else begin
      rx_pending <= nib_done || (rx_pending && !launch_now);
      if (!rx_frame) begin
        if (lvalid_s) begin
          rx_frame <= 1'b1;
          rx_bt    <= bitc >> 1;
          rx_cnt   <= '0;
          rx_errf  <= 1'b0;
        end
      end else if (!lvalid_s) begin
        rx_frame <= 1'b0;
      end else if (rx_bt != '0) begin
        rx_bt <= rx_bt - 1'b1;
      end else begin
        rx_bt  <= bitc - 1'b1;
        rx_sh  <= {lrx_s, rx_sh[3:1]};
        rx_cnt <= rx_cnt + 1'b1;
        if (nib_done) begin
          rx_nib  <= {rx_errf || lerr_s, lrx_s, rx_sh[3:1]};
          rx_errf <= 1'b0;
        end else begin
          rx_errf <= rx_errf || lerr_s;
        end
      end
    end
  end

  // outputs change only well clear of the receive clock rise
  assign launch_now = rx_pending && !rx_launched &&
                      (ctr >= mpit_pkg::RX_LAUNCH_FIRST) &&
                      (ctr <= per - mpit_pkg::RX_LAUNCH_TAIL);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxd         <= '0;
      rx_dv       <= 1'b0;
      rx_er       <= 1'b0;
      rx_launched <= 1'b0;
    end else begin
      if (ctr == '0) begin
        rx_launched <= 1'b0;
      end else if (launch_now) begin
        rx_launched <= 1'b1;
      end
      if (launch_now) begin
        rxd   <= rx_nib[3:0];
        rx_er <= rx_nib[4];
        rx_dv <= 1'b1;
      end else if (!rx_launched && (ctr == per - mpit_pkg::RX_LAUNCH_TAIL)) begin
        rxd   <= '0;
        rx_er <= 1'b0;
        rx_dv <= 1'b0;
      end
    end
  end

  assign next_hdr = {hdr[10:0], mdio_s};

  // management frame engine; acts on each detected management clock rise
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mg_state   <= mpit_pkg::MG_IDLE;
      pre_cnt    <= '0;
      mg_cnt     <= '0;
      hdr        <= '0;
      mg_sh      <= '0;
      mg_read    <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
      mgmt_addr  <= '0;
      mgmt_wdata <= '0;
      mgmt_write <= 1'b0;
    end else begin
      mgmt_write <= 1'b0;
      if (mdc_s && !mdc_d) begin
        case (mg_state)
          mpit_pkg::MG_IDLE: begin
            if (mdio_s) begin
              if (pre_cnt < mpit_pkg::MG_PRE_BITS) begin
                pre_cnt <= pre_cnt + 1'b1;
              end
            end else begin
              if (pre_cnt >= mpit_pkg::MG_PRE_BITS) begin
                mg_state <= mpit_pkg::MG_START;
              end
              pre_cnt <= '0;
            end
          end
          mpit_pkg::MG_START: begin
            mg_cnt   <= '0;
            mg_state <= mdio_s ? mpit_pkg::MG_HDR : mpit_pkg::MG_IDLE;
          end
          mpit_pkg::MG_HDR: begin
            hdr    <= next_hdr;
            mg_cnt <= mg_cnt + 1'b1;
            if (mg_cnt == mpit_pkg::MG_HDR_LAST) begin
              mg_cnt    <= '0;
              mg_read   <= next_hdr[11:10] == mpit_pkg::MG_OP_RD;
              mgmt_addr <= next_hdr[4:0];
              if (next_hdr[9:5] == PHY_ADDR &&
                  (next_hdr[11:10] == mpit_pkg::MG_OP_RD ||
                   next_hdr[11:10] == mpit_pkg::MG_OP_WR)) begin
                mg_state <= mpit_pkg::MG_DATA;
              end else begin
                mg_state <= mpit_pkg::MG_IDLE;
              end
            end
          end
          mpit_pkg::MG_DATA: begin
            mg_cnt <= mg_cnt + 1'b1;
            if (mg_read) begin
              if (mg_cnt == mpit_pkg::MG_TA_SLOT) begin
                mdio_oe  <= 1'b1;
                mdio_out <= 1'b0;
                mg_sh    <= mgmt_rdata;
              end else if (mg_cnt == mpit_pkg::MG_LAST) begin
                mdio_oe  <= 1'b0;
                mdio_out <= 1'b0;
              end else begin
                mdio_out <= mg_sh[15];
                mg_sh    <= {mg_sh[14:0], 1'b0};
              end
            end else if (mg_cnt >= mpit_pkg::MG_WR_FIRST) begin
              mg_sh <= {mg_sh[14:0], mdio_s};
              if (mg_cnt == mpit_pkg::MG_LAST) begin
                mgmt_wdata <= {mg_sh[14:0], mdio_s};
                mgmt_write <= 1'b1;
              end
            end
            if (mg_cnt == mpit_pkg::MG_LAST) begin
              mg_state <= mpit_pkg::MG_IDLE;
              pre_cnt  <= '0;
            end
          end
          default: mg_state <= mpit_pkg::MG_IDLE;
        endcase
      end
    end
  end

endmodule

// *** verification/mpit_top_monitor.sv ***
/*
  Checker for mpit_top: clock shape, receive launch window, carrier and
  management read timing, seen from the top ports only.
  Assumes it is bound into mpit_top and clk_sys runs at 100 MHz.
*/
`timescale 1ns/1ns
module mpit_top_monitor (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       full_duplex,
  input wire logic       tx_clk,
  input wire logic       tx_en,
  input wire logic       rx_clk,
  input wire logic [3:0] rxd,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic       crs,
  input wire logic       line_receive_valid,
  input wire logic       mdc,
  input wire logic       mdio_out,
  input wire logic       mdio_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [5:0] hi_len;
  logic [5:0] lo_len;
  logic [5:0] age;
  logic       seen;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) hi_len <= 6'h00;
    else hi_len <= tx_clk ? hi_len + 6'h01 : 6'h00;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) lo_len <= 6'h00;
    else lo_len <= tx_clk ? 6'h00 : lo_len + 6'h01;
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) seen <= 1'b0;
    else seen <= seen | tx_clk;
  end
  // cycles since the last management clock rise, saturating
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) age <= 6'h3F;
    else age <= $rose(mdc) ? 6'h00 : age + {5'h00, age != 6'h3F};
  end
  a_txclk_high: assert property ($fell(tx_clk) |-> hi_len == 6'h02 || hi_len == 6'h14)
    else $error("tx clock high phase has wrong length");
  a_txclk_low: assert property ($rose(tx_clk) && seen |-> lo_len == 6'h02 || lo_len == 6'h14)
    else $error("tx clock low phase has wrong length");
  a_rxclk_same: assert property (rx_clk == tx_clk)
    else $error("rx clock differs from tx clock");
  a_rx_launch_window: assert property ($rose(rx_clk) |->
    $stable({rxd, rx_dv, rx_er}) ##1 $stable({rxd, rx_dv, rx_er}))
    else $error("receive outputs change next to rx clock rise");
  a_crs_from_tx: assert property ((!full_duplex && tx_en) [*6] |-> crs)
    else $error("carrier missing during transmit");
  a_crs_release: assert property ((!tx_en && !line_receive_valid) [*8] |-> !crs)
    else $error("carrier held after transmit");
  a_mdio_bit_valid: assert property (mdio_oe && $changed(mdio_out) |-> age <= 6'h1C)
    else $error("management bit changes late after clock rise");
  a_mdio_bit_steady: assert property (mdio_oe && age > 6'h1E |-> $stable(mdio_out))
    else $error("management bit moves late in the cycle");
  a_mdio_turn_start: assert property ($rose(mdio_oe) |-> !mdio_out && age <= 6'h08)
    else $error("turnaround drive wrong");
endmodule

bind mpit_top mpit_top_monitor u_mon (
  .clk_sys(clk_sys), .nrst(nrst), .full_duplex(full_duplex), .tx_clk(tx_clk),
  .tx_en(tx_en), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs),
  .line_receive_valid(line_receive_valid), .mdc(mdc), .mdio_out(mdio_out),
  .mdio_oe(mdio_oe)
);

// *** verification/mpit_mac_model.sv ***
/*
  MAC and management station model: four-nibble transmit bursts on the
  transmit clock and management frames with a pulled-up data wire.
  Assumes clk_sys at 100 MHz paces all of its timing.
*/
`timescale 1ns/1ns
module mpit_mac_model (
  input  wire logic       clk_sys,
  input  wire logic       tx_clk,
  output logic      [3:0] txd,
  output logic            tx_en,
  output logic            tx_er,
  output logic            mdc,
  output logic            mdio_in,
  input  wire logic       mdio_out,
  input  wire logic       mdio_oe
);
  logic m_drive;
  logic m_bit;
  // wire level with a pull-up when nobody drives
  assign mdio_in = mdio_oe ? mdio_out : (m_drive ? m_bit : 1'b1);
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    tx_er = 1'b0;
    mdc = 1'b0;
    m_drive = 1'b0;
    m_bit = 1'b1;
  end
  task automatic send(input logic [15:0] d, input int er_at);
    int i;
    for (i = 0; i < 4; i++) begin
      @(posedge tx_clk);
      @(negedge clk_sys);
      tx_en = 1'b1;
      txd = d[4*i +: 4];
      tx_er = (i == er_at);
    end
    @(posedge tx_clk);
    @(negedge clk_sys);
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = ~txd;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    int i;
    f = {32'hFFFFFFFF, 2'b01, op, phy, rg, 2'b10, wd};
    for (i = 63; i >= 0; i--) begin
      m_drive = !(op == mpit_pkg::MG_OP_RD && i < 18);
      m_bit = f[i];
      repeat (10) @(negedge clk_sys);
      // read bits are taken just before the rise that ends them
      if (i < 16) rd[i] = mdio_in;
      mdc = 1'b1;
      repeat (20) @(negedge clk_sys);
      mdc = 1'b0;
      repeat (10) @(negedge clk_sys);
    end
    m_drive = 1'b0;
  endtask
endmodule

// *** verification/mpit_top_bench.sv ***
/*
  Self-checking bench for mpit_top: clocks, transmit, receive, management.
  Assumes the package, design files, model and checker are compiled first.
*/
`timescale 1ns/1ns
module mpit_top_bench;
  logic        clk_sys;
  logic        nrst;
  logic        speed_100;
  logic        full_duplex;
  logic        tx_clk;
  logic [3:0]  txd;
  logic        tx_en;
  logic        tx_er;
  logic        rx_clk;
  logic [3:0]  rxd;
  logic        rx_dv;
  logic        rx_er;
  logic        crs;
  logic        lt_pair;
  logic        lt_act;
  logic        lt_err;
  logic        lr_pair;
  logic        lr_valid;
  logic        lr_err;
  logic        lr_busy;
  logic        mdc;
  logic        mdio_in;
  logic        mdio_out;
  logic        mdio_oe;
  logic [15:0] mgmt_rdata;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic        mgmt_write;
  int          errors;
  int          n_tests;
  int          n_wr;
  mpit_top #(.PHY_ADDR(5'h03)) dut (
    .clk_sys(clk_sys), .nrst(nrst), .speed_100(speed_100), .full_duplex(full_duplex),
    .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er), .rx_clk(rx_clk),
    .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .crs(crs), .line_transmit_pair(lt_pair),
    .line_transmit_active(lt_act), .line_transmit_error(lt_err),
    .line_receive_pair(lr_pair), .line_receive_valid(lr_valid),
    .line_receive_error(lr_err), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .mgmt_rdata(mgmt_rdata), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_write(mgmt_write));
  mpit_mac_model mac (
    .clk_sys(clk_sys), .tx_clk(tx_clk), .txd(txd), .tx_en(tx_en), .tx_er(tx_er),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // an idle line never holds its last bit
  always @(negedge clk_sys) if (!lr_busy) lr_pair <= ~lr_pair;
  always @(posedge clk_sys) if (mgmt_write === 1'b1) n_wr++;
  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic set_mode(input logic f, input logic fd);
    @(negedge clk_sys);
    speed_100 = f;
    full_duplex = fd;
    repeat (100) @(negedge clk_sys);
  endtask
  task automatic test_clocks(input logic f);
    realtime t0, t1, t2;
    set_mode(f, 1'b0);
    @(posedge tx_clk);
    t0 = $realtime;
    @(negedge tx_clk);
    t1 = $realtime;
    @(posedge tx_clk);
    t2 = $realtime;
    chk(t2 - t0 == (f ? 40 : 400), "tx clock period");
    chk(t1 - t0 == (f ? 20 : 200), "tx clock high time");
    @(posedge rx_clk);
    t0 = $realtime;
    @(posedge rx_clk);
    chk($realtime - t0 == (f ? 40 : 400), "rx clock period");
    $display("clock test done, fast %0d", f);
  endtask
  task automatic test_tx(input logic f, input logic fd, input logic [15:0] d);
    logic [15:0] got;
    logic [3:0]  ge;
    time         t0;
    int          b;
    int          k;
    int          bc;
    bc = f ? 1 : 10;
    set_mode(f, fd);
    fork
      mac.send(d, 2);
    join_none
    @(posedge tx_en);
    if (!f) begin
      repeat (20) @(negedge clk_sys);
      chk(crs === 1'b1, "slow carrier late");
    end
    @(posedge tx_clk);
    t0 = $time;
    for (k = 0; k < 60 && lt_act !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    chk($time - 1 - t0 <= (f ? 30 : 200), "first line bit late");
    chk(crs === !fd, "carrier during transmit");
    repeat ((bc + 1) / 2) @(negedge clk_sys);
    for (b = 0; b < 16; b++) begin
      got[b] = lt_pair;
      ge[b/4] = lt_err;
      repeat (bc) @(negedge clk_sys);
    end
    chk(got === d, "line bits");
    chk(ge === 4'b0100, "line error flag");
    repeat (4) @(negedge clk_sys);
    chk(crs === 1'b0, "carrier after transmit");
    $display("transmit test done, fast %0d duplex %0d", f, fd);
  endtask
  task automatic test_rx(input logic f, input logic [7:0] d);
    logic [7:0] got;
    logic [1:0] ge;
    time        t0;
    int         n;
    int         k;
    set_mode(f, 1'b0);
    fork
      begin
        @(negedge clk_sys);
        lr_busy = 1'b1;
        @(negedge clk_sys);
        lr_valid = 1'b1;
        // fast sampling starts one bit after the frame is seen
        if (f) @(negedge clk_sys);
        for (int b = 0; b < 8; b++) begin
          lr_pair = d[b];
          lr_err = (b == 5);
          repeat (f ? 1 : 10) @(negedge clk_sys);
        end
        lr_valid = 1'b0;
        lr_err = 1'b0;
        lr_busy = 1'b0;
      end
    join_none
    @(posedge lr_valid);
    t0 = $time;
    for (k = 0; k < 100 && rx_dv !== 1'b1; k++) begin
      @(posedge clk_sys);
      #1;
    end
    if (!f) chk($time - 1 - t0 <= 700, "receive latency");
    n = 0;
    for (k = 0; k < 20 && n < 2; k++) begin
      @(posedge rx_clk);
      if (rx_dv === 1'b1) begin
        got[4*n +: 4] = rxd;
        ge[n] = rx_er;
        n++;
      end
    end
    chk(got === d, "receive nibbles");
    chk(ge === 2'b10, "receive error flag");
    $display("receive test done, fast %0d", f);
  endtask
  task automatic test_mgmt(input logic [1:0] op, input logic [4:0] phy, input logic [15:0] ex);
    logic [15:0] rd;
    logic        wr;
    int          w0;
    w0 = n_wr;
    wr = (op == mpit_pkg::MG_OP_WR) && (phy == 5'h03);
    mac.frame(op, phy, 5'h0D, 16'h6C39, rd);
    chk(rd === ex, "management data on wire");
    chk((n_wr - w0) == (wr ? 1 : 0), "write strobe count");
    if (phy == 5'h03) chk(mgmt_addr === 5'h0D, "management address");
    if (wr) chk(mgmt_wdata === 16'h6C39, "management write data");
    $display("management test done, op %0d", op);
  endtask
  initial begin
    errors = 0;
    n_tests = 0;
    n_wr = 0;
    nrst = 1'b0;
    speed_100 = 1'b1;
    full_duplex = 1'b0;
    lr_pair = 1'b0;
    lr_valid = 1'b0;
    lr_err = 1'b0;
    lr_busy = 1'b0;
    mgmt_rdata = 16'h9A47;
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    test_clocks(1'b1);
    test_clocks(1'b0);
    test_tx(1'b1, 1'b0, 16'hB2C5);
    test_tx(1'b0, 1'b0, 16'h3A96);
    test_tx(1'b1, 1'b1, 16'h5E01);
    test_rx(1'b0, 8'hD3);
    test_rx(1'b1, 8'h6A);
    test_mgmt(mpit_pkg::MG_OP_RD, 5'h03, 16'h9A47);
    test_mgmt(mpit_pkg::MG_OP_WR, 5'h03, 16'h6C39);
    test_mgmt(mpit_pkg::MG_OP_RD, 5'h11, 16'hFFFF);
    end_sim;
  end
  initial begin
    #400000;
    errors++;
    $display("wrong value at %0t: run did not finish", $time);
    end_sim;
  end
endmodule
